// file: src/ciae_top.sv
// external bus sequencer with per-space idle insertion and select stretch
//
// Design decisions made here: the register addresses and the AXI4-Lite register port.
`default_nettype none
module ciae_top
  import ciae_pkg::*;
(
  // clock and reset
  input  wire logic                I_CORE_CLK,
  input  wire logic                I_RSTN,
  // axi4-lite register port
  input  wire logic [AXI_AW-1:0]   I_AXI_AWADDR,
  input  wire logic                I_AXI_AWVALID,
  output logic                     O_AXI_AWREADY,
  input  wire logic [31:0]         I_AXI_WDATA,
  input  wire logic [3:0]          I_AXI_WSTRB,
  input  wire logic                I_AXI_WVALID,
  output logic                     O_AXI_WREADY,
  output logic [1:0]               O_AXI_BRESP,
  output logic                     O_AXI_BVALID,
  input  wire logic                I_AXI_BREADY,
  input  wire logic [AXI_AW-1:0]   I_AXI_ARADDR,
  input  wire logic                I_AXI_ARVALID,
  output logic                     O_AXI_ARREADY,
  output logic [31:0]              O_AXI_RDATA,
  output logic [1:0]               O_AXI_RRESP,
  output logic                     O_AXI_RVALID,
  input  wire logic                I_AXI_RREADY,
  // processor-side access request
  input  wire logic                I_REQ_VALID,
  output logic                     O_REQ_READY,
  input  wire logic [1:0]          I_REQ_SPACE,
  input  wire logic                I_REQ_WRITE,
  input  wire logic [EXT_AW-1:0]   I_REQ_ADDR,
  input  wire logic [31:0]         I_REQ_WDATA,
  input  wire logic [3:0]          I_REQ_BE,
  output logic                     O_RSP_VALID,
  output logic [31:0]              O_RSP_RDATA,
  // external memory pins
  output logic [3:0]               O_CHIP_SELECT_N,
  output logic                     O_READ_STROBE_N,
  output logic [3:0]               O_BYTE_WRITE_STROBE_N,
  output logic [EXT_AW-1:0]        O_EXT_ADDR,
  input  wire logic [31:0]         I_EXT_DATA,
  output logic [31:0]              O_EXT_DATA,
  output logic                     O_EXT_DATA_OE
);
  typedef struct packed {
    ciae_phase_e       phase;
    logic [1:0]        gap_cnt;
    logic [1:0]        idle_left;
    logic              have_prev;
    logic [1:0]        space;
    logic              write;
    logic              stretch;
    logic [EXT_AW-1:0] addr;
    logic [31:0]       wdata;
    logic [3:0]        be;
    logic [3:0]        cs_n;
    logic              rd_n;
    logic [3:0]        wr_n;
    logic              oe;
    logic [31:0]       din_meta;
    logic [31:0]       din_sync;
    logic [1:0]        cap_pipe;
    logic              rsp_valid;
    logic [31:0]       rsp_data;
  } ciae_top_s;

  ciae_top_s   st_ff;
  ciae_top_s   nxt_st;
  logic [15:0] control;
  logic [15:0] status;
  logic        last_cycle;
  logic        accept;
  logic [1:0]  need;
  logic [1:0]  have;
  logic [1:0]  iw_prev;
  logic        cw_new;
  logic        sw_new;

  assign status = {8'h00, st_ff.have_prev, st_ff.write, st_ff.space,
                   1'b0, 3'(st_ff.phase)};

  ciae_regs u_regs (
    .I_CORE_CLK (I_CORE_CLK),
    .I_RSTN     (I_RSTN),
    .i_awaddr   (I_AXI_AWADDR),
    .i_awvalid  (I_AXI_AWVALID),
    .o_awready  (O_AXI_AWREADY),
    .i_wdata    (I_AXI_WDATA),
    .i_wstrb    (I_AXI_WSTRB),
    .i_wvalid   (I_AXI_WVALID),
    .o_wready   (O_AXI_WREADY),
    .o_bresp    (O_AXI_BRESP),
    .o_bvalid   (O_AXI_BVALID),
    .i_bready   (I_AXI_BREADY),
    .i_araddr   (I_AXI_ARADDR),
    .i_arvalid  (I_AXI_ARVALID),
    .o_arready  (O_AXI_ARREADY),
    .o_rdata    (O_AXI_RDATA),
    .o_rresp    (O_AXI_RRESP),
    .o_rvalid   (O_AXI_RVALID),
    .i_rready   (I_AXI_RREADY),
    .o_control  (control),
    .i_status   (status)
  );

  // the last bus cycle may overlap a new request so back-to-back needs no gap
  assign last_cycle = (st_ff.phase == CIAE_TRAIL) ||
                      (st_ff.phase == CIAE_T2 && !st_ff.stretch);
  assign O_REQ_READY = (st_ff.phase == CIAE_IDLE) || last_cycle;
  assign accept      = I_REQ_VALID && O_REQ_READY;

  // settings of the spaces involved, sampled only when a cycle starts
  assign iw_prev = control[IDLE_READ_LSB + 2*st_ff.space +: 2];
  assign cw_new  = control[CONT_IDLE_LSB + I_REQ_SPACE];
  assign sw_new  = control[STRETCH_LSB + I_REQ_SPACE];

  always_comb begin
    need = 2'h0;
    if (st_ff.have_prev) begin
      if (st_ff.space == I_REQ_SPACE) begin
        need = {1'b0, cw_new};
        if (!st_ff.write && I_REQ_WRITE && iw_prev > need) begin
          need = iw_prev;
        end
      end else if (!st_ff.write) begin
        need = iw_prev;
      end
    end
    // deselected cycles already spent since the last access count toward the gap
    if (last_cycle) begin
      have = 2'h0;
    end else if (st_ff.gap_cnt == GAP_MAX) begin
      have = GAP_MAX;
    end else begin
      have = st_ff.gap_cnt + 2'h1;
    end
  end

  always_comb begin
    nxt_st          = st_ff;
    nxt_st.din_meta = I_EXT_DATA;
    nxt_st.din_sync = st_ff.din_meta;
    nxt_st.cap_pipe = {st_ff.cap_pipe[0], 1'b0};
    nxt_st.rsp_valid = st_ff.cap_pipe[1];
    if (st_ff.cap_pipe[1]) begin
      nxt_st.rsp_data = st_ff.din_sync;
    end
    if ((st_ff.phase == CIAE_IDLE || st_ff.phase == CIAE_GAP) &&
        st_ff.gap_cnt != GAP_MAX) begin
      nxt_st.gap_cnt = st_ff.gap_cnt + 2'h1;
    end
    case (st_ff.phase)
      CIAE_IDLE: begin
      end
      CIAE_GAP: begin
        if (st_ff.idle_left == 2'h1) begin
          nxt_st.phase = st_ff.stretch ? CIAE_LEAD : CIAE_T1;
        end
        nxt_st.idle_left = st_ff.idle_left - 2'h1;
      end
      CIAE_LEAD: begin
        nxt_st.phase = CIAE_T1;
      end
      CIAE_T1: begin
        nxt_st.phase = CIAE_T2;
      end
      CIAE_T2: begin
        nxt_st.cap_pipe[0] = 1'b1;
        nxt_st.phase       = st_ff.stretch ? CIAE_TRAIL : CIAE_IDLE;
        if (!st_ff.stretch) begin
          nxt_st.gap_cnt = 2'h0;
        end
      end
      CIAE_TRAIL: begin
        nxt_st.phase   = CIAE_IDLE;
        nxt_st.gap_cnt = 2'h0;
      end
      default: begin
        nxt_st.phase = CIAE_IDLE;
      end
    endcase
    if (accept) begin
      nxt_st.have_prev = 1'b1;
      nxt_st.space     = I_REQ_SPACE;
      nxt_st.write     = I_REQ_WRITE;
      nxt_st.stretch   = sw_new;
      nxt_st.addr      = I_REQ_ADDR;
      nxt_st.wdata     = I_REQ_WDATA;
      nxt_st.be        = I_REQ_BE;
      if (need > have) begin
        nxt_st.phase     = CIAE_GAP;
        nxt_st.idle_left = need - have;
      end else begin
        nxt_st.phase = sw_new ? CIAE_LEAD : CIAE_T1;
      end
    end
    // pins follow the next phase so that they come straight from flip-flops
    nxt_st.cs_n = 4'hf;
    nxt_st.rd_n = 1'b1;
    nxt_st.wr_n = 4'hf;
    nxt_st.oe   = 1'b0;
    case (nxt_st.phase)
      CIAE_LEAD: begin
        nxt_st.cs_n[nxt_st.space] = 1'b0;
      end
      CIAE_T1, CIAE_T2: begin
        nxt_st.cs_n[nxt_st.space] = 1'b0;
        nxt_st.rd_n = nxt_st.write;
        nxt_st.wr_n = nxt_st.write ? ~nxt_st.be : 4'hf;
        nxt_st.oe   = nxt_st.write;
      end
      CIAE_TRAIL: begin
        nxt_st.cs_n[nxt_st.space] = 1'b0;
        nxt_st.oe = nxt_st.write;
      end
      default: begin
        nxt_st.cs_n = 4'hf;
      end
    endcase
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      st_ff         <= '0;
      st_ff.phase   <= CIAE_IDLE;
      st_ff.gap_cnt <= GAP_MAX;
      st_ff.cs_n    <= 4'hf;
      st_ff.rd_n    <= 1'b1;
      st_ff.wr_n    <= 4'hf;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign O_CHIP_SELECT_N       = st_ff.cs_n;
  assign O_READ_STROBE_N       = st_ff.rd_n;
  assign O_BYTE_WRITE_STROBE_N = st_ff.wr_n;
  assign O_EXT_ADDR            = st_ff.addr;
  assign O_EXT_DATA            = st_ff.wdata;
  assign O_EXT_DATA_OE         = st_ff.oe;
  assign O_RSP_VALID           = st_ff.rsp_valid;
  assign O_RSP_RDATA           = st_ff.rsp_data;
endmodule // ciae_top
`default_nettype wire

// file: src/ciae_pkg.sv
// package: constants and types for the chip-select idle and stretch controller
// Summary of operation
// - continuous-idle bits 7:4, spaces 3:0, reset 1
// - continuous idle bit 1 adds one idle cycle
// - select deasserted during inserted idle cycle
// - write after read: larger count, not sum
// - select-stretch bits 3:0, spaces 3:0, reset 1
// - stretch bit adds leading and trailing select cycles
// - stretch bit 0 adds no extra cycles
// - with stretch bit 1, strobes lie strictly inside select window; with stretch bit 0 they span the whole select window
// - idle-after-read two-bit field gives 0..3 cycles
// - extra cycles: select only; write data held
`default_nettype none
package ciae_pkg;
  localparam int          AXI_AW         = 8;
  localparam int          EXT_AW         = 20;
  localparam logic [7:0]  OFS_CONTROL    = 8'h00;
  localparam logic [7:0]  OFS_STATUS     = 8'h04;
  localparam logic [15:0] CONTROL_RESET  = 16'hffff;
  localparam int          IDLE_READ_LSB  = 8;
  localparam int          CONT_IDLE_LSB  = 4;
  localparam int          STRETCH_LSB    = 0;
  localparam logic [1:0]  GAP_MAX        = 2'h3;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  typedef enum logic [2:0] {
    CIAE_IDLE,
    CIAE_GAP,
    CIAE_LEAD,
    CIAE_T1,
    CIAE_T2,
    CIAE_TRAIL
  } ciae_phase_e;
endpackage : ciae_pkg
`default_nettype wire

// file: src/ciae_regs.sv
// axi4-lite slave holding the control register and a status view
`default_nettype none
module ciae_regs
  import ciae_pkg::*;
(
  // clock and reset
  input  wire logic                I_CORE_CLK,
  input  wire logic                I_RSTN,
  // axi4-lite write
  input  wire logic [AXI_AW-1:0]   i_awaddr,
  input  wire logic                i_awvalid,
  output logic                     o_awready,
  input  wire logic [31:0]         i_wdata,
  input  wire logic [3:0]          i_wstrb,
  input  wire logic                i_wvalid,
  output logic                     o_wready,
  output logic [1:0]               o_bresp,
  output logic                     o_bvalid,
  input  wire logic                i_bready,
  // axi4-lite read
  input  wire logic [AXI_AW-1:0]   i_araddr,
  input  wire logic                i_arvalid,
  output logic                     o_arready,
  output logic [31:0]              o_rdata,
  output logic [1:0]               o_rresp,
  output logic                     o_rvalid,
  input  wire logic                i_rready,
  // block side
  output logic [15:0]              o_control,
  input  wire logic [15:0]         i_status
);
  typedef struct packed {
    logic              aw_have;
    logic [AXI_AW-1:0] aw_addr;
    logic              w_have;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [1:0]        rresp;
    logic [31:0]       rdata;
    logic [15:0]       control;
  } ciae_regs_s;

  ciae_regs_s st_ff;
  ciae_regs_s nxt_st;

  assign o_awready = !st_ff.aw_have && !st_ff.bvalid;
  assign o_wready  = !st_ff.w_have && !st_ff.bvalid;
  assign o_arready = !st_ff.rvalid;
  assign o_bvalid  = st_ff.bvalid;
  assign o_bresp   = st_ff.bresp;
  assign o_rvalid  = st_ff.rvalid;
  assign o_rresp   = st_ff.rresp;
  assign o_rdata   = st_ff.rdata;
  assign o_control = st_ff.control;

  always_comb begin
    nxt_st = st_ff;
    if (i_awvalid && o_awready) begin
      nxt_st.aw_have = 1'b1;
      nxt_st.aw_addr = i_awaddr;
    end
    if (i_wvalid && o_wready) begin
      nxt_st.w_have = 1'b1;
      nxt_st.w_data = i_wdata;
      nxt_st.w_strb = i_wstrb;
    end
    // address and data may come in either order
    if (nxt_st.aw_have && nxt_st.w_have) begin
      nxt_st.aw_have = 1'b0;
      nxt_st.w_have  = 1'b0;
      nxt_st.bvalid  = 1'b1;
      nxt_st.bresp   = RESP_OKAY;
      if (nxt_st.aw_addr == OFS_CONTROL) begin
        if (nxt_st.w_strb[0]) nxt_st.control[7:0] = nxt_st.w_data[7:0];
        if (nxt_st.w_strb[1]) nxt_st.control[15:8] = nxt_st.w_data[15:8];
      end else if (nxt_st.aw_addr != OFS_STATUS) begin
        nxt_st.bresp = RESP_SLVERR;
      end
    end
    if (st_ff.bvalid && i_bready) begin
      nxt_st.bvalid = 1'b0;
    end
    if (st_ff.rvalid && i_rready) begin
      nxt_st.rvalid = 1'b0;
    end
    if (i_arvalid && o_arready) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp  = RESP_OKAY;
      nxt_st.rdata  = 32'h0000_0000;
      if (i_araddr == OFS_CONTROL) begin
        nxt_st.rdata[15:0] = st_ff.control;
      end else if (i_araddr == OFS_STATUS) begin
        nxt_st.rdata[15:0] = i_status;
      end else begin
        nxt_st.rresp = RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      st_ff         <= '0;
      st_ff.control <= CONTROL_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule // ciae_regs
`default_nettype wire

// file: tb/ciae_mem_model.sv
// partner: external memory behind the select and strobe pins
`default_nettype none
module ciae_mem_model (
  // pins from the controller
  input  wire logic        i_clk,
  input  wire logic [3:0]  i_cs_n,
  input  wire logic        i_rd_n,
  input  wire logic [3:0]  i_wr_n,
  input  wire logic [19:0] i_addr,
  input  wire logic [31:0] i_data,
  // read data back
  output logic      [31:0] o_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] mem_ff [16];
  logic [31:0] last_ff = '0;
  always_ff @(posedge i_clk) begin
    if (i_cs_n != 4'hf && i_wr_n != 4'hf) mem_ff[i_addr[3:0]] <= i_data;
    last_ff <= o_data;
  end
  // released bus shows the inverse of the previous cycle, so a stale word does not pass in the first released cycle
  assign o_data = (i_cs_n != 4'hf && !i_rd_n) ? mem_ff[i_addr[3:0]] : ~last_ff;
endmodule // ciae_mem_model
`default_nettype wire

// file: tb/ciae_top_props.sv
// checker: strobe and select relations at the controller pins
`default_nettype none
module ciae_top_props (
  // clock and reset
  input wire logic       I_CORE_CLK,
  input wire logic       I_RSTN,
  // watched ports
  input wire logic       I_AXI_BREADY,
  input wire logic       O_AXI_BVALID,
  input wire logic [3:0] O_CHIP_SELECT_N,
  input wire logic       O_READ_STROBE_N,
  input wire logic [3:0] O_BYTE_WRITE_STROBE_N,
  input wire logic       O_EXT_DATA_OE
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RSTN);
  logic sel;
  logic wr;
  assign sel = O_CHIP_SELECT_N != 4'hf;
  assign wr = O_BYTE_WRITE_STROBE_N != 4'hf;
  a_rd_in_sel: assert property (!O_READ_STROBE_N |-> sel)
    else $error("read strobe outside select");
  a_wr_in_sel: assert property (wr |-> sel)
    else $error("write strobe outside select");
  a_one_sel: assert property ($countones(~O_CHIP_SELECT_N) <= 1)
    else $error("two selects at once");
  a_strobe_excl: assert property (!O_READ_STROBE_N |-> !wr)
    else $error("read and write strobes together");
  a_rd_width: assert property ($fell(O_READ_STROBE_N) |=> !O_READ_STROBE_N)
    else $error("read strobe too short");
  a_wr_oe: assert property (wr |-> O_EXT_DATA_OE)
    else $error("write strobe without data");
  // same select on both sides: a new space's leading cycle is not a trailing one
  a_trail_data: assert property ($rose(!wr) && sel && $stable(O_CHIP_SELECT_N) &&
    O_READ_STROBE_N |-> O_EXT_DATA_OE)
    else $error("write data dropped in trailing cycle");
  a_b_hold: assert property (O_AXI_BVALID && !I_AXI_BREADY |=> O_AXI_BVALID)
    else $error("write response dropped");
  a_b_done: assert property (O_AXI_BVALID && I_AXI_BREADY |=> !O_AXI_BVALID)
    else $error("write response not retired");
endmodule // ciae_top_props
bind ciae_top ciae_top_props u_props (.*);
`default_nettype wire

// file: tb/testbench.sv
// bench: register port, select run and gap lengths, readback
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import ciae_pkg::*;
  logic I_CORE_CLK = 0, I_RSTN = 0, I_AXI_AWVALID = 0, I_AXI_WVALID = 0, I_AXI_BREADY = 0;
  logic I_AXI_ARVALID = 0, I_AXI_RREADY = 0, I_REQ_VALID = 0, I_REQ_WRITE = 0;
  logic O_AXI_AWREADY, O_AXI_WREADY, O_AXI_BVALID, O_AXI_ARREADY, O_AXI_RVALID;
  logic O_REQ_READY, O_RSP_VALID, O_READ_STROBE_N, O_EXT_DATA_OE;
  logic [AXI_AW-1:0] I_AXI_AWADDR = '0, I_AXI_ARADDR = '0;
  logic [31:0] I_AXI_WDATA = '0, I_REQ_WDATA = '0, I_EXT_DATA, O_AXI_RDATA, O_RSP_RDATA;
  logic [31:0] O_EXT_DATA;
  logic [3:0] I_AXI_WSTRB = '0, I_REQ_BE = 4'hf, O_CHIP_SELECT_N, O_BYTE_WRITE_STROBE_N;
  logic [3:0] prv = 4'hf;
  logic [1:0] I_REQ_SPACE = '0, O_AXI_BRESP, O_AXI_RRESP;
  logic [EXT_AW-1:0] I_REQ_ADDR = '0, O_EXT_ADDR;
  int fail_count = 0, n_checks = 0, len = 0;
  int run_q[$], gap_q[$];
  logic [31:0] rd_q[$];

  ciae_top DUT (.*);
  ciae_mem_model u_mem (.i_clk(I_CORE_CLK), .i_cs_n(O_CHIP_SELECT_N),
    .i_rd_n(O_READ_STROBE_N), .i_wr_n(O_BYTE_WRITE_STROBE_N), .i_addr(O_EXT_ADDR),
    .i_data(O_EXT_DATA), .o_data(I_EXT_DATA));

  always #25 I_CORE_CLK = ~I_CORE_CLK;

  // select run lengths and idle gaps, sampled mid-cycle once settled
  always @(negedge I_CORE_CLK) begin
    if (O_CHIP_SELECT_N !== prv) begin
      if (prv != 4'hf) run_q.push_back(len);
      if (O_CHIP_SELECT_N != 4'hf) gap_q.push_back(prv == 4'hf ? len : 0);
      len = 1;
    end else len++;
    prv = O_CHIP_SELECT_N;
    if (O_RSP_VALID === 1'b1) rd_q.push_back(O_RSP_RDATA);
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                        input logic [1:0] er);
    logic aw, w;
    aw = 0;
    w = 0;
    @(posedge I_CORE_CLK);
    I_AXI_AWADDR <= a;
    I_AXI_WDATA <= d;
    I_AXI_WSTRB <= s;
    I_AXI_AWVALID <= 1;
    I_AXI_WVALID <= 1;
    I_AXI_BREADY <= 1;
    while (!(aw && w)) begin
      @(negedge I_CORE_CLK);
      aw = aw | O_AXI_AWREADY;
      w = w | O_AXI_WREADY;
      @(posedge I_CORE_CLK);
      I_AXI_AWVALID <= !aw;
      I_AXI_WVALID <= !w;
    end
    do @(negedge I_CORE_CLK); while (O_AXI_BVALID !== 1'b1);
    chk({30'h0, O_AXI_BRESP}, {30'h0, er});
    @(posedge I_CORE_CLK);
    I_AXI_BREADY <= 0;
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge I_CORE_CLK);
    I_AXI_ARADDR <= a;
    I_AXI_ARVALID <= 1;
    I_AXI_RREADY <= 1;
    do @(negedge I_CORE_CLK); while (O_AXI_ARREADY !== 1'b1);
    @(posedge I_CORE_CLK);
    I_AXI_ARVALID <= 0;
    do @(negedge I_CORE_CLK); while (O_AXI_RVALID !== 1'b1);
    chk(O_AXI_RDATA, ed);
    chk({30'h0, O_AXI_RRESP}, {30'h0, er});
    @(posedge I_CORE_CLK);
    I_AXI_RREADY <= 0;
  endtask

  // entered at a rising edge, leaves at the edge that took the request
  task automatic acc(input logic [1:0] s, input logic w, input logic [19:0] a);
    I_REQ_VALID <= 1;
    I_REQ_SPACE <= s;
    I_REQ_WRITE <= w;
    I_REQ_ADDR <= a;
    I_REQ_WDATA <= {12'h0, a} ^ 32'h5a00_0000;
    do @(negedge I_CORE_CLK); while (O_REQ_READY !== 1'b1);
    @(posedge I_CORE_CLK);
  endtask

  // two back-to-back accesses: total select cycles and the gap between them
  task automatic pair(input logic [15:0] c, input logic [1:0] s0, input logic w0,
                      input logic [1:0] s1, input logic w1, input int er, input int eg);
    axi_wr(OFS_CONTROL, {16'h0, c}, 4'hf, RESP_OKAY);
    repeat (6) @(posedge I_CORE_CLK);
    run_q.delete();
    gap_q.delete();
    acc(s0, w0, 20'h3);
    acc(s1, w1, 20'h3);
    I_REQ_VALID <= 0;
    repeat (16) @(posedge I_CORE_CLK);
    chk(run_q.sum(), er);
    chk(gap_q.size() > 1 ? gap_q[1] : 0, eg);
  endtask

  initial begin
    repeat (20) @(posedge I_CORE_CLK);
    I_RSTN <= 1;
    axi_rd(OFS_CONTROL, 32'h0000_ffff, RESP_OKAY);
    axi_wr(8'h08, 32'h1, 4'hf, RESP_SLVERR);
    axi_rd(8'h08, 32'h0, RESP_SLVERR);
    axi_wr(OFS_CONTROL, 32'h0000_a55a, 4'h1, RESP_OKAY);
    axi_rd(OFS_CONTROL, 32'h0000_ff5a, RESP_OKAY);
    pair(16'h0000, 0, 0, 0, 0, 4, 0);
    pair(16'h00f0, 0, 0, 0, 0, 4, 1);
    pair(16'h000f, 1, 0, 1, 1, 8, 0);
    pair(16'h3040, 2, 0, 2, 1, 4, 3);
    pair(16'h0040, 2, 0, 2, 1, 4, 1);
    for (int k = 0; k < 4; k++) pair(16'(k << 14), 3, 0, 0, 0, 4, k);
    pair(16'hffff, 1, 1, 2, 0, 8, 0);
    pair(16'h0010, 1, 0, 1, 0, 4, 0);
    pair(16'h0000, 0, 1, 0, 0, 4, 0);
    chk(rd_q[$], 32'h5a00_0003);
    // mid-run reset must bring every control bit back to one
    I_RSTN <= 0;
    repeat (2) @(posedge I_CORE_CLK);
    I_RSTN <= 1;
    axi_rd(OFS_CONTROL, 32'h0000_ffff, RESP_OKAY);
    final_report();
  end

  initial begin
    repeat (5000) @(posedge I_CORE_CLK);
    fail_count++;
    final_report();
  end
endmodule // testbench
`default_nettype wire
